/* File: hw/palette_pkg.sv */
// shared constants and carriers for the palette lookup front end
package palette_pkg;
    localparam int PIX_W = 4;
    localparam int PTR_W = 5;
    localparam int HDATA_W = 5;
    localparam int NIB_W = 4;
    localparam int COLOR_W = 12;
    localparam int PAL_DEPTH = 16;
    localparam int OVL_COUNT = 3;
    localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
    localparam logic [PTR_W-1:0] PTR_OVL_BASE = 5'h10;
    localparam logic [PTR_W-1:0] PTR_OVL_LAST = 5'h12;
    localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
    localparam logic [COLOR_W-1:0] COLOR_RESET = 12'h000;
    localparam logic [NIB_W-1:0] BLANK_CODE = 4'h0;
    localparam logic [1:0] OVL_NONE = 2'h0;
    // sync pulse removes a 40 IRE step on green only
    localparam int SYNC_IRE = 40;

    typedef enum logic [2:0] {
        PH_RED = 3'b001,
        PH_GREEN = 3'b010,
        PH_BLUE = 3'b100
    } color_phase_e;

    typedef struct packed {
        logic [PIX_W-1:0] pixel_index;
        logic [1:0] overlay_choice;
        logic sync_n;
        logic blank_n;
    } pixel_in_s;

    typedef struct packed {
        logic [NIB_W-1:0] red;
        logic [NIB_W-1:0] green;
        logic [NIB_W-1:0] blue;
        logic blank_n;
        logic green_sync_on;
    } dac_out_s;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic port_target_select;
        logic [HDATA_W-1:0] data;
    } host_in_s;
endpackage : palette_pkg

/* File: hw/sync2.sv */
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync2 width must be positive");
    end

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // reset to all ones: every host strobe is idle high
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : sync2

/* File: hw/palette_lookup_front_end.sv */
// palette lookup front end: pixel path and asynchronous host port
// What this block does
// - blank low forces all three converter codes to the blanking level
// - blank low makes the pixel and overlay inputs of that cycle ignored
// - sync low switches off the 40 IRE sync current on green only
// - pixel index, overlay choice, sync and blank captured together each edge
// - four-bit pixel index, bit 0 least significant, picks one of 16 entries
// - a nonzero overlay choice ignores the pixel index; bit 0 least significant
// - host reads and writes act only while device select is low
// - write data is captured when select or write strobe rises first
// - data bus is driven only while select and read strobe are both low
// - target select low reaches the pointer, high the addressed colour
// - host data moves over five bidirectional lines, bit 0 least significant
// - five-bit pointer: 00-0F palette, 10-12 overlay colours one to three
// - red, green, blue accesses; a blue write stores the 12-bit word, any blue access steps pointer
// - phase counter clears on a pointer write, not on a pointer read
// - overlay choice 00 uses the palette, 01-11 overlay colours one to three
`timescale 1ns/1ps
module palette_lookup_front_end
    import palette_pkg::*;
#(
    parameter int ENTRIES = PAL_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pixel side, already synchronous to sys_clk
    input wire pixel_in_s pixel_in,
    // converter side
    output dac_out_s dac_out,
    // asynchronous host port
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic port_target_select,
    input wire logic [HDATA_W-1:0] host_data_bus_in,
    output logic [HDATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe
);
    if (ENTRIES != PAL_DEPTH) begin : g_bad_depth
        $error("palette depth must be 16");
    end

    // ------------------------------------------------------------
    // host pin synchronisation
    // ------------------------------------------------------------
    host_in_s host_raw;
    host_in_s host_s;
    assign host_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                        port_target_select: port_target_select,
                        data: host_data_bus_in};

    sync2 #(.WIDTH($bits(host_in_s))) u_host_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(host_raw),
        .sync_out(host_s)
    );

    // ------------------------------------------------------------
    // host access decode
    // ------------------------------------------------------------
    logic wr_act;
    logic rd_act;
    logic wr_act_q;
    logic rd_act_q;
    logic sel_q;
    logic [HDATA_W-1:0] wdata_q;
    logic wr_done;
    logic rd_done;
    logic [HDATA_W-1:0] wdata_d;
    logic sel_d;

    // rd and wr low together with select is undefined; write wins here
    assign wr_act = !host_s.cs_n && !host_s.wr_n;
    assign rd_act = !host_s.cs_n && !host_s.rd_n && host_s.wr_n;
    // the access completes when the active window closes: cs or its strobe (wr or rd) rising
    assign wr_done = wr_act_q && !wr_act;
    assign rd_done = rd_act_q && !rd_act;

    always_comb begin
        // data is sampled while the window is open so the last value before
        // the first rising edge is the one kept
        wdata_d = wr_act ? host_s.data : wdata_q;
        sel_d = (wr_act || rd_act) ? host_s.port_target_select : sel_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            wdata_q <= '0;
            sel_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            wdata_q <= wdata_d;
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // pointer, phase and colour storage
    // ------------------------------------------------------------
    logic [PTR_W-1:0] palette_pointer_q;
    logic [PTR_W-1:0] palette_pointer_d;
    color_phase_e color_phase_count_q;
    color_phase_e color_phase_count_d;
    logic [NIB_W-1:0] red_hold_q;
    logic [NIB_W-1:0] red_hold_d;
    logic [NIB_W-1:0] green_hold_q;
    logic [NIB_W-1:0] green_hold_d;
    logic [COLOR_W-1:0] palette_mem [PAL_DEPTH];
    logic [COLOR_W-1:0] overlay_q [OVL_COUNT];
    logic store_en;
    logic [COLOR_W-1:0] store_word;
    logic [COLOR_W-1:0] read_word;
    logic [1:0] ovl_slot;
    logic color_acc;

    assign color_acc = (wr_done || rd_done) && sel_q;
    assign store_en = wr_done && sel_q && (color_phase_count_q == PH_BLUE);
    assign store_word = {red_hold_q, green_hold_q, wdata_q[NIB_W-1:0]};
    assign ovl_slot = 2'(palette_pointer_q - PTR_OVL_BASE);

    always_comb begin
        read_word = COLOR_RESET;
        if (palette_pointer_q < PTR_OVL_BASE) begin
            read_word = palette_mem[palette_pointer_q[PIX_W-1:0]];
        end else if (palette_pointer_q <= PTR_OVL_LAST) begin
            read_word = overlay_q[ovl_slot];
        end
    end

    always_comb begin
        palette_pointer_d = palette_pointer_q;
        color_phase_count_d = color_phase_count_q;
        red_hold_d = red_hold_q;
        green_hold_d = green_hold_q;
        if (wr_done && !sel_q) begin
            palette_pointer_d = wdata_q;
            color_phase_count_d = PH_RED;
        end else if (color_acc) begin
            case (color_phase_count_q)
                PH_RED: begin
                    red_hold_d = wdata_q[NIB_W-1:0];
                    color_phase_count_d = PH_GREEN;
                end
                PH_GREEN: begin
                    green_hold_d = wdata_q[NIB_W-1:0];
                    color_phase_count_d = PH_BLUE;
                end
                PH_BLUE: begin
                    color_phase_count_d = PH_RED;
                    palette_pointer_d = palette_pointer_q + PTR_ONE;
                end
                default: begin
                    color_phase_count_d = PH_RED;
                end
            endcase
        end
    end

    // whole-word store in one sys_clk edge: the lookup sees old or new, never half
    always_ff @(posedge sys_clk) begin
        if (store_en && palette_pointer_q < PTR_OVL_BASE) begin
            palette_mem[palette_pointer_q[PIX_W-1:0]] <= store_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            palette_pointer_q <= PTR_RESET;
            color_phase_count_q <= PH_RED;
            red_hold_q <= '0;
            green_hold_q <= '0;
            for (int i = 0; i < OVL_COUNT; i++) begin
                overlay_q[i] <= COLOR_RESET;
            end
        end else begin
            palette_pointer_q <= palette_pointer_d;
            color_phase_count_q <= color_phase_count_d;
            red_hold_q <= red_hold_d;
            green_hold_q <= green_hold_d;
            if (store_en && palette_pointer_q >= PTR_OVL_BASE
                && palette_pointer_q <= PTR_OVL_LAST) begin
                overlay_q[ovl_slot] <= store_word;
            end
        end
    end

    // ------------------------------------------------------------
    // host read data
    // ------------------------------------------------------------
    logic [HDATA_W-1:0] rdata_d;
    logic [HDATA_W-1:0] rdata_q;
    logic oe_d;
    logic oe_q;

    always_comb begin
        oe_d = rd_act;
        rdata_d = {HDATA_W{1'b0}};
        if (!host_s.port_target_select) begin
            rdata_d = palette_pointer_q;
        end else begin
            // top data line reads zero during colour reads
            case (color_phase_count_q)
                PH_RED: rdata_d = {1'b0, read_word[COLOR_W-1 -: NIB_W]};
                PH_GREEN: rdata_d = {1'b0, read_word[2*NIB_W-1 -: NIB_W]};
                PH_BLUE: rdata_d = {1'b0, read_word[NIB_W-1:0]};
                default: rdata_d = {HDATA_W{1'b0}};
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_q <= '0;
            oe_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            oe_q <= oe_d;
        end
    end

    assign host_data_bus_out = rdata_q;
    assign host_data_bus_oe = oe_q;

    // ------------------------------------------------------------
    // pixel path: capture, lookup, output register
    // ------------------------------------------------------------
    pixel_in_s pix_q;
    pixel_in_s pix_d;
    dac_out_s dac_q;
    dac_out_s dac_d;
    logic [COLOR_W-1:0] color_sel;

    assign pix_d = pixel_in;

    always_comb begin
        if (pix_q.overlay_choice == OVL_NONE) begin
            color_sel = palette_mem[pix_q.pixel_index];
        end else begin
            color_sel = overlay_q[2'(pix_q.overlay_choice - 2'h1)];
        end
        dac_d.blank_n = pix_q.blank_n;
        dac_d.green_sync_on = pix_q.sync_n;
        if (!pix_q.blank_n) begin
            dac_d.red = BLANK_CODE;
            dac_d.green = BLANK_CODE;
            dac_d.blue = BLANK_CODE;
        end else begin
            dac_d.red = color_sel[COLOR_W-1 -: NIB_W];
            dac_d.green = color_sel[2*NIB_W-1 -: NIB_W];
            dac_d.blue = color_sel[NIB_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pix_q <= '{pixel_index: '0, overlay_choice: OVL_NONE, sync_n: 1'b1,
                       blank_n: 1'b0};
            dac_q <= '{red: BLANK_CODE, green: BLANK_CODE, blue: BLANK_CODE,
                       blank_n: 1'b0, green_sync_on: 1'b1};
        end else begin
            pix_q <= pix_d;
            dac_q <= dac_d;
        end
    end

    assign dac_out = dac_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_blue_write;
        wr_done && sel_q && color_phase_count_q == PH_BLUE;
    endsequence

    property p_blank_forces;
        @(posedge sys_clk) disable iff (!reset_n)
        !pixel_in.blank_n |=> ##1 (dac_out.red == BLANK_CODE && dac_out.green == BLANK_CODE
                                   && dac_out.blue == BLANK_CODE && !dac_out.blank_n);
    endproperty
    a_blank_forces: assert property (p_blank_forces) else $error("blank not forced");

    property p_sync_green;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> ##1 (dac_out.green_sync_on == $past(pixel_in.sync_n, 2));
    endproperty
    a_sync_green: assert property (p_sync_green) else $error("sync flag wrong");

    property p_capture;
        @(posedge sys_clk) disable iff (!reset_n)
        1'b1 |=> (pix_q == $past(pixel_in));
    endproperty
    a_capture: assert property (p_capture) else $error("pixel capture wrong");

    property p_cs_gates;
        @(posedge sys_clk) disable iff (!reset_n)
        host_s.cs_n |=> !host_data_bus_oe;
    endproperty
    a_cs_gates: assert property (p_cs_gates) else $error("driven while deselected");

    property p_oe_read;
        @(posedge sys_clk) disable iff (!reset_n)
        host_data_bus_oe |-> $past(!host_s.cs_n && !host_s.rd_n);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");

    property p_ptr_write;
        @(posedge sys_clk) disable iff (!reset_n)
        (wr_done && !sel_q) |=> (palette_pointer_q == $past(wdata_q)
                                 && color_phase_count_q == PH_RED);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer write wrong");

    property p_blue_step;
        @(posedge sys_clk) disable iff (!reset_n)
        s_blue_write |=> (palette_pointer_q == 5'($past(palette_pointer_q) + PTR_ONE));
    endproperty
    a_blue_step: assert property (p_blue_step) else $error("pointer not stepped");

    property p_ptr_read_keeps;
        @(posedge sys_clk) disable iff (!reset_n)
        (rd_done && !sel_q) |=> $stable(color_phase_count_q);
    endproperty
    a_ptr_read_keeps: assert property (p_ptr_read_keeps) else $error("phase cleared");
endmodule : palette_lookup_front_end

/* File: verification/pixel_source_model.sv */
// stand-in for the frame buffer and video timing logic feeding the pixel side
`timescale 1ns/1ps
module pixel_source_model
    import palette_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pixel the bench asks for
    input wire pixel_in_s want,
    // registered pixel and controls
    output pixel_in_s pixel_in
);
    // ----------------------------------------
    // output register
    // ----------------------------------------
    pixel_in_s pix_d;
    pixel_in_s pix_q;

    always_comb begin
        pix_d = want;
        // sync has no priority over anything, so it only ever goes out inside blanking
        pix_d.sync_n = want.sync_n | want.blank_n;
        if (!reset_n) begin
            pix_d = '{pixel_index: 4'h0, overlay_choice: OVL_NONE, sync_n: 1'b1, blank_n: 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        pix_q <= pix_d;
    end

    assign pixel_in = pix_q;
endmodule : pixel_source_model

/* File: verification/palette_lookup_front_end_bench.sv */
// self-checking bench for the palette lookup front end
`timescale 1ns/1ps
module palette_lookup_front_end_bench;
    import palette_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    pixel_in_s want;
    pixel_in_s pixel_in;
    dac_out_s dac_out;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic c0;
    logic [HDATA_W-1:0] bench_data;
    logic [HDATA_W-1:0] bus_out;
    logic bus_oe;
    logic [HDATA_W-1:0] bus_wire;
    logic [COLOR_W-1:0] pal [PAL_DEPTH];
    logic [COLOR_W-1:0] ovl [OVL_COUNT];
    int n_fail = 0;
    int samples_checked = 0;

    always #2 sys_clk = ~sys_clk;

    // the device owns the wire while enabled; otherwise the bench level shows
    assign bus_wire = bus_oe ? bus_out : bench_data;

    pixel_source_model pixel_source_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .want(want), .pixel_in(pixel_in));

    palette_lookup_front_end palette_lookup_front_end_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .pixel_in(pixel_in), .dac_out(dac_out), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port_target_select(c0), .host_data_bus_in(bus_wire),
        .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_bus(input string what, input logic [HDATA_W-1:0] exp,
                             input logic [HDATA_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_bus

    task automatic check_dac(input string what, input dac_out_s exp, input dac_out_s got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_dac

    // read and write strobes are never low together
    task automatic host_write(input logic sel, input logic [HDATA_W-1:0] d, input logic chip);
        c0 <= sel;
        bench_data <= d;
        tick(4);
        cs_n <= chip;
        wr_n <= 1'b0;
        tick(6);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        tick(1);
        bench_data <= ~d;
        tick(6);
    endtask : host_write

    // select rises while the write strobe stays low; later data must not land
    task automatic host_write_cs_first(input logic [HDATA_W-1:0] d);
        c0 <= 1'b0;
        bench_data <= d;
        tick(4);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        tick(6);
        cs_n <= 1'b1;
        tick(1);
        bench_data <= ~d;
        tick(6);
        wr_n <= 1'b1;
        tick(6);
    endtask : host_write_cs_first

    task automatic host_read(input logic sel, input logic [HDATA_W-1:0] exp, input logic chip);
        c0 <= sel;
        tick(4);
        cs_n <= chip;
        rd_n <= 1'b0;
        tick(6);
        @(negedge sys_clk);
        check_bus("bus enable", HDATA_W'(!chip), HDATA_W'(bus_oe));
        if (!chip) check_bus("read data", exp, bus_wire);
        @(posedge sys_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        tick(6);
        @(negedge sys_clk);
        check_bus("bus released", 5'h00, HDATA_W'(bus_oe));
        @(posedge sys_clk);
    endtask : host_read

    function automatic dac_out_s expect_dac(input pixel_in_s p);
        logic [COLOR_W-1:0] c;
        c = p.overlay_choice == OVL_NONE ? pal[p.pixel_index] : ovl[p.overlay_choice - 2'h1];
        if (!p.blank_n) begin
            return '{red: BLANK_CODE, green: BLANK_CODE, blue: BLANK_CODE, blank_n: 1'b0,
                     green_sync_on: p.sync_n};
        end
        return '{red: c[11:8], green: c[7:4], blue: c[3:0], blank_n: 1'b1, green_sync_on: 1'b1};
    endfunction : expect_dac

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_load_palette();
        logic [COLOR_W-1:0] c;
        host_write(1'b0, 5'h00, 1'b0);
        for (int i = 0; i < PAL_DEPTH + OVL_COUNT; i++) begin
            c = {4'(i), ~4'(i), 4'(i) ^ 4'h5};
            if (i < PAL_DEPTH) pal[i] = c;
            else ovl[i - PAL_DEPTH] = c;
            host_write(1'b1, {1'b0, c[11:8]}, 1'b0);
            host_write(1'b1, {1'b0, c[7:4]}, 1'b0);
            host_write(1'b1, {1'b0, c[3:0]}, 1'b0);
        end
        host_read(1'b0, 5'h13, 1'b0);
        $display("test palette load done");
    endtask : t_load_palette

    task automatic t_readback();
        host_write(1'b0, 5'h03, 1'b0);
        host_read(1'b1, {1'b0, pal[3][11:8]}, 1'b0);
        host_read(1'b0, 5'h03, 1'b0);
        host_read(1'b1, {1'b0, pal[3][7:4]}, 1'b0);
        host_write(1'b0, 5'h03, 1'b0);
        host_read(1'b1, {1'b0, pal[3][11:8]}, 1'b0);
        $display("test readback done");
    endtask : t_readback

    task automatic t_deselect();
        host_write(1'b0, 5'h07, 1'b1);
        host_read(1'b0, 5'h03, 1'b1);
        host_write(1'b1, 5'h0F, 1'b1);
        host_read(1'b0, 5'h03, 1'b0);
        host_read(1'b1, {1'b0, pal[3][7:4]}, 1'b0);
        $display("test deselected strobes done");
    endtask : t_deselect

    task automatic t_write_edge();
        host_read(1'b1, {1'b0, pal[3][3:0]}, 1'b0);
        host_read(1'b0, 5'h04, 1'b0);
        host_write_cs_first(5'h05);
        host_read(1'b0, 5'h05, 1'b0);
        $display("test blue read and first rising edge done");
    endtask : t_write_edge

    task automatic t_pixels();
        pixel_in_s seq [22];
        for (int j = 0; j < 22; j++) begin
            seq[j].pixel_index = PIX_W'(j);
            seq[j].overlay_choice = j > 15 ? 2'(j - 15) : OVL_NONE;
            seq[j].blank_n = j != 19 && j != 20;
            seq[j].sync_n = j < 20;
        end
        // model register plus two design stages puts each pixel three edges later
        for (int j = 0; j < 25; j++) begin
            @(posedge sys_clk);
            if (j < 22) want <= seq[j];
            @(negedge sys_clk);
            if (j >= 3) check_dac("converter codes", expect_dac(seq[j - 3]), dac_out);
        end
        @(posedge sys_clk);
        want <= '{pixel_index: 4'h0, overlay_choice: OVL_NONE, sync_n: 1'b1, blank_n: 1'b0};
        $display("test pixel stream done");
    endtask : t_pixels

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        want = '{pixel_index: 4'h0, overlay_choice: OVL_NONE, sync_n: 1'b1, blank_n: 1'b0};
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        c0 = 1'b0;
        bench_data = 5'h00;
        tick(16);
        reset_n <= 1'b1;
        tick(4);
        t_load_palette();
        t_readback();
        t_deselect();
        t_write_edge();
        t_pixels();
        report_and_stop();
    end

    initial begin
        tick(100000);
        n_fail++;
        $display("run limit reached");
        report_and_stop();
    end
endmodule : palette_lookup_front_end_bench
